/* File: hw/smsr_fen_latch.sv */
// Fire-enable latch timer for one fire-enable function
`timescale 1ns/1ps
`default_nettype none
`include "smsr_defs.svh"
module smsr_fen_latch import smsr_pkg::*; #(
   parameter int unsigned P_T128_CYC = `SMSR_T128_CYC,
   parameter int unsigned P_T256_CYC = `SMSR_T256_CYC,
   parameter int unsigned P_T512_CYC = `SMSR_T512_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_level,
   input wire logic [1:0] i_dur_sel,
   output logic o_active
);
   logic [10:0] high_cnt, next_high_cnt;
   logic [25:0] tmr, next_tmr;
   logic busy, next_busy, level_q;
   logic qualified;

   assign qualified = high_cnt >= 11'(`SMSR_QUAL_CYC);

   // High-time qualifier, falling-edge start and countdown
   always_comb begin
      next_high_cnt = high_cnt;
      next_tmr = tmr;
      next_busy = busy;
      if (!i_level) begin
         next_high_cnt = '0;
      end else if (!qualified) begin
         next_high_cnt = high_cnt + 11'h001;
      end
      if (busy) begin
         next_tmr = tmr - 26'h0000001;
         next_busy = tmr != '0;
      end
      if (level_q && !i_level && qualified) begin
         unique case (i_dur_sel)
            `SMSR_DUR_OFF: next_busy = 1'b0;
            `SMSR_DUR_128: next_tmr = 26'(P_T128_CYC - 1);
            `SMSR_DUR_256: next_tmr = 26'(P_T256_CYC - 1);
            default: next_tmr = 26'(P_T512_CYC - 1);
         endcase
         if (i_dur_sel != `SMSR_DUR_OFF) begin
            next_busy = 1'b1;
         end
      end
   end

   // State registers
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         high_cnt <= '0;
         tmr <= '0;
         busy <= 1'b0;
         level_q <= 1'b0;
      end else begin
         high_cnt <= next_high_cnt;
         tmr <= next_tmr;
         busy <= next_busy;
         level_q <= i_level;
      end
   end

   assign o_active = i_level | busy;

   // Checks on qualification, start of the timer and the output while it runs
   AST_FEN_SHORT_PULSE: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      (level_q && !i_level && !qualified && !busy) |=> !busy)
      else $error("latch started after a short high pulse");
   AST_FEN_START_LOAD: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      (level_q && !i_level && qualified && i_dur_sel == `SMSR_DUR_128)
      |=> busy && tmr == 26'(P_T128_CYC - 1))
      else $error("latch timer not loaded with its duration");
   AST_FEN_OR: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      busy && $past(busy) && tmr != '0 |=> o_active)
      else $error("fire-enable dropped while timer runs");
   COV_FEN_START: cover property (@(posedge i_clk_sys)
      disable iff (!i_rst_b) $rose(busy));
endmodule
`default_nettype wire

/* File: hw/smsr_top.sv */
// Serial monitor readout: status and identification queries
`timescale 1ns/1ps
`default_nettype none
`include "smsr_defs.svh"
module smsr_top import smsr_pkg::*; #(
   parameter int unsigned P_T128_CYC = `SMSR_T128_CYC,
   parameter int unsigned P_T256_CYC = `SMSR_T256_CYC,
   parameter int unsigned P_T512_CYC = `SMSR_T512_CYC,
   parameter logic [3:0] P_DEVICE_CODE = `SMSR_DEV_CODE, // Arbitrary value
   parameter logic [5:0] P_REVISION = `SMSR_REV_CODE // Arbitrary value
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_spi_sclk,
   input wire logic i_spi_cs_b,
   input wire logic i_spi_mosi,
   output logic o_spi_miso,
   output logic o_spi_miso_oe,
   input wire logic i_fire_enable_one,
   input wire logic i_fire_enable_two,
   input wire logic [1:0] i_fire_enable_one_time,
   input wire logic [1:0] i_fire_enable_two_time,
   input wire logic [3:0] i_current_threshold
);
   // ---- Link domain (serial clock) ----
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [14:0] shift, next_shift;
   smsr_word_t rx_word;
   logic rx_tog;

   // Bit counter and shifter, cleared by chip select high
   always_comb begin
      next_bit_cnt = bit_cnt;
      next_shift = {shift[13:0], i_spi_mosi};
      if (bit_cnt != `SMSR_CNT_FULL) begin
         next_bit_cnt = bit_cnt + 5'h01;
      end
   end

   always_ff @(posedge i_spi_sclk or posedge i_spi_cs_b) begin
      if (i_spi_cs_b) begin
         bit_cnt <= '0;
         shift <= '0;
      end else begin
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
      end
   end

   // Word handed over with a toggle on the sixteenth edge
   always_ff @(posedge i_spi_sclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_word <= '0;
         rx_tog <= 1'b0;
      end else if (!i_spi_cs_b && bit_cnt == `SMSR_CNT_LAST) begin
         rx_word <= {shift, i_spi_mosi};
         rx_tog <= ~rx_tog;
      end
   end

   // ---- System domain ----
   logic [2:0] cs_s, tog_s, fe1_s, fe2_s;
   logic [3:0] cur_s1, cur_s2, cur_s3;
   logic cs_act, tog_seen, fe1_lvl, fe2_lvl;
   logic [3:0] cur;
   logic fe1, fe2;
   smsr_word_t resp, next_resp, built;
   smsr_resp_kind_t kind, next_kind;
   logic sel, next_sel, por_ok, next_por_ok;
   logic rx_evt, rx_ok;
   logic [7:0] data8;

   // Three-stage synchronisers for pins and the toggle
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         cs_s <= 3'h7;
         tog_s <= '0;
         fe1_s <= '0;
         fe2_s <= '0;
         cur_s1 <= '0;
         cur_s2 <= '0;
         cur_s3 <= '0;
      end else begin
         cs_s <= {cs_s[1:0], i_spi_cs_b};
         tog_s <= {tog_s[1:0], rx_tog};
         fe1_s <= {fe1_s[1:0], i_fire_enable_one};
         fe2_s <= {fe2_s[1:0], i_fire_enable_two};
         cur_s1 <= i_current_threshold;
         cur_s2 <= cur_s1;
         cur_s3 <= cur_s2;
      end
   end

   // Filtered levels change once stages two and three agree
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         cs_act <= 1'b0;
         tog_seen <= 1'b0;
         fe1_lvl <= 1'b0;
         fe2_lvl <= 1'b0;
      end else begin
         if (cs_s[1] == cs_s[2]) cs_act <= ~cs_s[2];
         if (fe1_s[1] == fe1_s[2]) fe1_lvl <= fe1_s[2];
         if (fe2_s[1] == fe2_s[2]) fe2_lvl <= fe2_s[2];
         if (rx_evt) tog_seen <= tog_s[2];
      end
   end

   // Per-channel current flags, filtered per bit
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cur
         always_ff @(posedge i_clk_sys) begin
            if (!i_rst_b) begin
               cur[gi] <= 1'b0;
            end else if (cur_s2[gi] == cur_s3[gi]) begin
               cur[gi] <= cur_s3[gi];
            end
         end
      end
   endgenerate

   // Latch timers for both fire-enable functions
   smsr_fen_latch #(
      .P_T128_CYC(P_T128_CYC),
      .P_T256_CYC(P_T256_CYC),
      .P_T512_CYC(P_T512_CYC)
   ) u_fen_one (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_level(fe1_lvl),
      .i_dur_sel(i_fire_enable_one_time),
      .o_active(fe1)
   );

   smsr_fen_latch #(
      .P_T128_CYC(P_T128_CYC),
      .P_T256_CYC(P_T256_CYC),
      .P_T512_CYC(P_T512_CYC)
   ) u_fen_two (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_level(fe2_lvl),
      .i_dur_sel(i_fire_enable_two_time),
      .o_active(fe2)
   );

   // Command decode: header, odd parity and zero padding
   assign rx_evt = (tog_s[1] == tog_s[2]) && (tog_s[2] != tog_seen);
   always_comb begin
      rx_ok = (^rx_word) && rx_word[15:14] == `SMSR_HDR;
      if (rx_word[12:10] == `SMSR_MODE_ST) begin
         rx_ok = rx_ok && rx_word[8:0] == '0;
      end else if (rx_word[12:10] == `SMSR_MODE_ID) begin
         rx_ok = rx_ok && rx_word[9:0] == '0;
      end else begin
         rx_ok = 1'b0;
      end
   end

   // Reply word built from live state with odd parity
   always_comb begin
      data8 = sel ? {6'h00, fe2, fe1} : {4'h0, cur};
      unique case (kind)
         smsr_rk_status: built = {`SMSR_HDR, 1'b0, `SMSR_MODE_ST, sel,
                                  por_ok, data8};
         smsr_rk_id: built = {`SMSR_HDR, 1'b0, `SMSR_MODE_ID,
                              P_DEVICE_CODE, P_REVISION};
      endcase
      built[`SMSR_B_PAR] = ~^built;
   end

   // Reply frozen while chip select is low; flag set when read
   always_comb begin
      next_kind = kind;
      next_sel = sel;
      next_por_ok = por_ok;
      next_resp = cs_act ? resp : built;
      if (rx_evt && rx_ok) begin
         next_kind = rx_word[10] ? smsr_rk_id : smsr_rk_status;
         next_sel = rx_word[`SMSR_B_SEL];
      end
      if (cs_act && kind == smsr_rk_status) begin
         next_por_ok = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         resp <= `SMSR_RESP_RST;
         kind <= smsr_rk_status;
         sel <= 1'b0;
         por_ok <= 1'b0;
      end else begin
         resp <= next_resp;
         kind <= next_kind;
         sel <= next_sel;
         por_ok <= next_por_ok;
      end
   end

   // Reply shifted out MSB first; index follows the bit counter
   assign o_spi_miso = (!i_spi_cs_b && !bit_cnt[4]) ?
                       resp[4'hF - bit_cnt[3:0]] : 1'b0;
   assign o_spi_miso_oe = !i_spi_cs_b;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);

   AST_POR_ZERO_AFTER_RESET: assert property (
      $rose(i_rst_b) |-> !por_ok)
      else $error("reset flag not zero after reset");
   AST_POR_SET_ON_READ: assert property ($rose(por_ok) |->
      $past(cs_act) && $past(kind) == smsr_rk_status)
      else $error("reset flag set without a status read");
   AST_FEN_REPLY: assert property
      (!cs_act && kind == smsr_rk_status && sel |=>
       resp[7:0] == {6'h00, $past(fe2), $past(fe1)})
      else $error("fire-enable reply bits wrong");
   AST_CUR_REPLY: assert property
      (!cs_act && kind == smsr_rk_status && !sel |=>
       resp[7:0] == {4'h0, $past(cur)} && !resp[`SMSR_B_SEL])
      else $error("current reply bits wrong");
   AST_FROZEN_IN_FRAME: assert property
      (cs_act && $past(cs_act) |-> $stable(resp))
      else $error("reply changed inside a frame");
   AST_ID_REPLY: assert property (!cs_act && kind == smsr_rk_id |=>
      resp[12:0] == {`SMSR_MODE_ID, P_DEVICE_CODE, P_REVISION})
      else $error("identification reply wrong");
   AST_ODD_PARITY: assert property (
      ^resp && resp[15:14] == `SMSR_HDR)
      else $error("reply parity not odd");
   // Decode lands while chip select is still low, so the echo is
   // checked on the reply loaded once the frame has ended
   AST_SEL_ECHO: assert property (!cs_act && kind == smsr_rk_status
      |=> resp[`SMSR_B_SEL] == $past(sel))
      else $error("select not echoed");
   AST_SEL_TAKEN: assert property (rx_evt && rx_ok && !rx_word[10]
      |=> kind == smsr_rk_status && sel == $past(rx_word[`SMSR_B_SEL]))
      else $error("status query select not taken");
   COV_STATUS_QUERY: cover property (rx_evt && rx_ok && !rx_word[10]);
   COV_ID_QUERY: cover property (rx_evt && rx_ok && rx_word[10]);
   COV_POR_READ: cover property ($rose(por_ok));
   COV_BAD_FRAME: cover property (rx_evt && !rx_ok);
endmodule
`default_nettype wire

/* File: include/smsr_defs.svh */
// Constants of the monitor status readout block
`ifndef SMSR_DEFS_SVH
`define SMSR_DEFS_SVH
`define SMSR_CLK_MHZ 100
`define SMSR_QUAL_US 16
`define SMSR_QUAL_CYC (`SMSR_QUAL_US * `SMSR_CLK_MHZ)
`define SMSR_T128_MS 128
`define SMSR_T256_MS 256
`define SMSR_T512_MS 512
`define SMSR_T128_CYC (`SMSR_T128_MS * 1000 * `SMSR_CLK_MHZ)
`define SMSR_T256_CYC (`SMSR_T256_MS * 1000 * `SMSR_CLK_MHZ)
`define SMSR_T512_CYC (`SMSR_T512_MS * 1000 * `SMSR_CLK_MHZ)
`define SMSR_DUR_OFF 2'h0
`define SMSR_DUR_128 2'h1
`define SMSR_DUR_256 2'h2
`define SMSR_CNT_LAST 5'h0F
`define SMSR_CNT_FULL 5'h10
`define SMSR_HDR 2'h3
`define SMSR_MODE_ST 3'h2
`define SMSR_MODE_ID 3'h3
`define SMSR_B_PAR 13
`define SMSR_B_SEL 9
`define SMSR_RESP_RST 16'hC800
`define SMSR_DEV_CODE 4'h5
`define SMSR_REV_CODE 6'h01
`endif

/* File: include/smsr_pkg.sv */
// Types of the monitor status readout block
package smsr_pkg;
   typedef logic [15:0] smsr_word_t;
   typedef enum logic {smsr_rk_status, smsr_rk_id} smsr_resp_kind_t;
endpackage

/* File: sim/smsr_host.sv */
// Host serial master model that frames commands on a 125 ns link clock
`timescale 1ns/1ps
`default_nettype none
module smsr_host (
   input wire logic i_miso,
   input wire logic i_miso_oe,
   output logic o_sclk,
   output logic o_cs_b,
   output logic o_mosi
);
   logic line_last;
   logic line_seen;

   // A released reply line shows the inverse of its last driven level
   always @(i_miso or i_miso_oe) begin
      if (i_miso_oe) begin
         line_last = i_miso;
      end
   end
   assign line_seen = i_miso_oe ? i_miso : ~line_last;

   // Link clock idles low, the chip select idles high
   initial begin
      o_sclk = 1'h0;
      o_cs_b = 1'h1;
      o_mosi = 1'h0;
   end

   // One whole 16-bit frame, MSB first, reply MSB taken before the first rising edge, the rest on falling edges
   task automatic xfer(input logic [15:0] cmd, output logic [15:0] resp);
      o_cs_b = 1'h0;
      o_mosi = cmd[15];
      #62.5;
      resp[15] = line_seen;
      for (int k = 1; k <= 16; k++) begin
         o_sclk = 1'h1;
         #62.5;
         o_sclk = 1'h0;
         if (k < 16) begin
            resp[15 - k] = line_seen;
            o_mosi = cmd[15 - k];
         end
         #62.5;
      end
      o_cs_b = 1'h1;
      o_mosi = ~o_mosi; // Unselected data line does not hold its value
      #250;
   endtask
endmodule
`default_nettype wire

/* File: sim/smsr_top_bench.sv */
// Self-checking bench of the monitor status readout block
`timescale 1ns/1ps
`default_nettype none
`define SMSR_CHK(nm, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         $display("[FAIL] %s exp %h got %h", nm, exp, got); \
         miscompares++; \
      end \
   end
module smsr_top_bench;
   localparam logic [3:0] DEV_CODE = 4'h9; // Arbitrary value
   localparam logic [5:0] REV_CODE = 6'h2A; // Arbitrary value
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic sclk, cs_b, mosi, miso, miso_oe;
   logic fen_one = 1'h0;
   logic fen_two = 1'h0;
   logic [1:0] t_one = 2'h0;
   logic [1:0] t_two = 2'h0;
   logic [3:0] thr = 4'h0;
   logic [15:0] r;
   int miscompares = 0;
   int check_count = 0;

   // System clock at 100 MHz
   initial begin
      forever #5 clk = ~clk;
   end

   smsr_top #(.P_T128_CYC(200), .P_T256_CYC(400), .P_T512_CYC(800),
      .P_DEVICE_CODE(DEV_CODE), .P_REVISION(REV_CODE)) i_dut (
      .i_clk_sys(clk), .i_rst_b(rst_b), .i_spi_sclk(sclk),
      .i_spi_cs_b(cs_b), .i_spi_mosi(mosi), .o_spi_miso(miso),
      .o_spi_miso_oe(miso_oe), .i_fire_enable_one(fen_one),
      .i_fire_enable_two(fen_two), .i_fire_enable_one_time(t_one),
      .i_fire_enable_two_time(t_two), .i_current_threshold(thr));

   smsr_host i_host (.i_miso(miso), .i_miso_oe(miso_oe), .o_sclk(sclk),
      .o_cs_b(cs_b), .o_mosi(mosi));

   // Frame words with odd parity over all sixteen bits
   function automatic logic [15:0] par(input logic [15:0] w);
      par = {w[15:14], ~^{w[15:14], w[12:0]}, w[12:0]};
   endfunction
   function automatic logic [15:0] st_cmd(input logic sel);
      st_cmd = par({2'h3, 1'h0, 3'h2, sel, 9'h000});
   endfunction
   function automatic logic [15:0] st_word(input logic sel, input logic fl,
      input logic [7:0] d);
      st_word = par({2'h3, 1'h0, 3'h2, sel, fl, d});
   endfunction
   function automatic logic [15:0] id_word(input logic [9:0] body);
      id_word = par({2'h3, 1'h0, 3'h3, body});
   endfunction

   // Step to just after a system clock edge
   task automatic at_edge(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Frame start is offset from the system clock phase
   task automatic frame(input logic [15:0] cmd);
      #3.7;
      i_host.xfer(cmd, r);
   endtask

   task automatic t_reset_flag;
      frame(st_cmd(1'h1));
      `SMSR_CHK("reset reply", st_word(1'h0, 1'h0, 8'h00), r)
      at_edge(1);
      fen_one = 1'h1;
      at_edge(10);
      frame(st_cmd(1'h0));
      `SMSR_CHK("fen pin", st_word(1'h1, 1'h1, 8'h01), r)
      at_edge(1);
      fen_one = 1'h0;
   endtask

   task automatic t_current;
      at_edge(1);
      thr = 4'hA;
      at_edge(10);
      fork
         frame(st_cmd(1'h0));
         begin
            at_edge(60);
            thr = 4'h5;
            `SMSR_CHK("oe in frame", 1'h1, miso_oe)
         end
      join
      `SMSR_CHK("current", st_word(1'h0, 1'h1, 8'h0A), r)
      `SMSR_CHK("oe idle", 1'h0, miso_oe)
   endtask

   task automatic t_ident;
      frame(id_word(10'h000));
      `SMSR_CHK("current late", st_word(1'h0, 1'h1, 8'h05), r)
      frame(id_word(10'h000));
      `SMSR_CHK("ident", id_word({DEV_CODE, REV_CODE}), r)
   endtask

   task automatic t_refused;
      logic [15:0] cmds [3];
      cmds[0] = id_word(10'h000) ^ 16'h2000;
      cmds[1] = par(st_cmd(1'h0) | 16'h0001);
      cmds[2] = st_cmd(1'h1);
      for (int i = 0; i < 3; i++) begin
         frame(cmds[i]);
         `SMSR_CHK("refused", id_word({DEV_CODE, REV_CODE}), r)
      end
   endtask

   task automatic t_latch(input int hi_cyc, input logic [1:0] d1,
      input logic [1:0] d2);
      logic [7:0] fe_exp;
      at_edge(1);
      fe_exp = {6'h00, hi_cyc > 1600 && d2 != 2'h0,
         hi_cyc > 1600 && d1 != 2'h0};
      t_one = d1;
      t_two = d2;
      fen_one = 1'h1;
      fen_two = 1'h1;
      at_edge(hi_cyc);
      fen_one = 1'h0;
      fen_two = 1'h0;
      at_edge(3);
      frame(st_cmd(1'h1));
      `SMSR_CHK("latch on", st_word(1'h1, 1'h1, fe_exp), r)
      at_edge(850);
      frame(st_cmd(1'h1));
      `SMSR_CHK("latch off", st_word(1'h1, 1'h1, 8'h00), r)
   endtask

   task automatic results;
      if (miscompares == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      results();
   end

   // Main sequence
   initial begin
      at_edge(20);
      rst_b = 1'h1;
      at_edge(10);
      t_reset_flag();
      t_current();
      t_ident();
      t_refused();
      for (int d = 0; d < 4; d++) begin
         t_latch(1700, 2'(d), 2'(3 - d));
      end
      t_latch(1000, 2'h3, 2'h3);
      results();
   end
endmodule
`default_nettype wire
